// ---- rtl/svm_ctrl.sv ----
/*
 supply monitor control: byte registers, synchronised comparator, interrupt and reset requests.
 assumes the analog comparator supplies cmp_low_raw, and that the reset-cause and interrupt
 controller logic outside take low_supply_reset_req and low_supply_irq.
*/
`timescale 1ns/1ns
module svm_ctrl
  import svm_pkg::*;
#(
  parameter int SETTLE_CYC = SVM_SETTLE_CYC
) (
  // clock and resets
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        rst_by_monitor,
  // register port
  input  wire svm_bus_t    bus,
  output logic [7:0]       rdata,
  // comparator and outputs
  input  wire logic        cmp_low_raw,
  output logic [3:0]       threshold_code,
  output logic             comparator_on,
  output logic             low_supply_irq,
  output logic             low_supply_reset_req,
  output logic             low_supply_irq_mask,
  output logic             low_supply_reset_cause,
  output logic             settle_done
);

  svm_ctrl_t             ctrl_reg;
  logic [7:0]            level_reg;
  logic                  sync1_reg;
  logic                  sync2_reg;
  logic                  flag;
  logic [31:0]           settle_cnt_reg;
  logic                  wr_ctrl;
  logic                  wr_level;

  assign wr_ctrl  = bus.wr && (bus.addr == SVM_CTRL_ADDR);
  assign wr_level = bus.wr && (bus.addr == SVM_LEVEL_ADDR);

  // detector reset keeps the settings so software can see why it restarted
  always_ff @(posedge clk_sys) begin
    if (rst && !rst_by_monitor) begin
      ctrl_reg <= '{enable: SVM_CTRL_RST[SVM_EN_BIT], reset_mode: SVM_CTRL_RST[SVM_MODE_BIT]}; // R8
    end else if (!rst && wr_ctrl) begin
      ctrl_reg.enable     <= bus.wdata[SVM_EN_BIT];   // R1
      ctrl_reg.reset_mode <= bus.wdata[SVM_MODE_BIT]; // R3
    end
  end

  // forbidden codes are stored as written; the analog side decides what they mean
  always_ff @(posedge clk_sys) begin
    if (rst && !rst_by_monitor) begin
      level_reg <= SVM_LEVEL_RST; // R9
    end else if (!rst && wr_level) begin
      level_reg <= bus.wdata; // R10
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !ctrl_reg.enable) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= cmp_low_raw; // R20
      sync2_reg <= sync1_reg;   // R20
    end
  end

  assign flag = ctrl_reg.enable && sync2_reg; // R4

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_supply_irq       <= 1'b0;
      low_supply_reset_req <= 1'b0;
    end else begin
      low_supply_irq       <= flag && !ctrl_reg.reset_mode; // R6
      low_supply_reset_req <= flag && ctrl_reg.reset_mode;  // R7
    end
  end

  // analog settings follow the kept registers through a detector reset
  always_ff @(posedge clk_sys) begin
    if (rst && !rst_by_monitor) begin
      comparator_on        <= 1'b0;                              // R8
      threshold_code       <= SVM_LEVEL_RST[SVM_CODE_W-1:0];     // R9
    end else begin
      comparator_on        <= ctrl_reg.enable;              // R1
      threshold_code       <= level_reg[SVM_CODE_W-1:0];    // R10
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_supply_irq_mask <= 1'b1; // R18
    end else begin
      low_supply_irq_mask <= low_supply_irq_mask;
    end
  end

  // cause bit set by the detector reset itself; other resets clear it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_supply_reset_cause <= rst_by_monitor; // R19
    end
  end

  // settle counter gives software a visible ready level after enable
  always_ff @(posedge clk_sys) begin
    if (rst || !ctrl_reg.enable) begin
      settle_cnt_reg <= 32'h0000_0000;
      settle_done    <= 1'b0;
    end else if (settle_cnt_reg < 32'(SETTLE_CYC)) begin
      settle_cnt_reg <= settle_cnt_reg + 32'h0000_0001;
      settle_done    <= 1'b0;
    end else begin
      settle_done    <= 1'b1; // R2
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus.rd && bus.addr == SVM_CTRL_ADDR) begin
      rdata <= 8'h00;
      rdata[SVM_EN_BIT]   <= ctrl_reg.enable;
      rdata[SVM_MODE_BIT] <= ctrl_reg.reset_mode;
      rdata[SVM_FLAG_BIT] <= flag; // R5
    end else if (bus.rd && bus.addr == SVM_LEVEL_ADDR) begin
      rdata <= level_reg;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // svm_ctrl

// ---- shared/svm_pkg.sv ----
/*
 shared constants and types for the supply monitor control block.
 assumes a single clk_sys domain and a byte-wide register port at the documented offsets.
*/
// What the document requires of this block and its software
// R1: writing enable bit 7 high starts the comparator, low stops detection.
// R2: software waits the settling time after enabling before trusting the flag.
// R3: mode bit 1 picks interrupt (0) or internal reset (1) on low supply.
// R4: flag bit 0 reads 1 while supply is low, else 0 or when disabled.
// R5: control bit 0 is read-only; writes never change it.
// R6: interrupt request follows the flag only when enabled and in interrupt mode.
// R7: reset mode holds internal reset while supply is low, releases when adequate.
// R8: control register clears on any reset except one caused by the detector.
// R9: level register clears on any reset except one caused by the detector.
// R10: four-bit level picks one of ten thresholds; codes 10 to 15 forbidden.
// R11: software writes zero to control bits 2 through 6.
// R12: software writes zero to level register bits 4 through 7.
// R13: software disables detection before changing the level field.
// R14: stop reset mode by writing 00H, or clear mode then enable.
// R15: reset-mode start: mask, set level, enable, wait, confirm flag, set mode.
// R16: interrupt-mode start ends: clear pending, unmask, enable vectored interrupts.
// R17: software masks the detector interrupt before enabling detection.
// R18: any reset sets the detector interrupt mask flag to 1.
// R19: a detector-caused reset sets reset-cause bit 0 to 1.
// R20: comparator output passes two flip-flops before driving flag, request or reset.
package svm_pkg;
  localparam logic [15:0] SVM_CTRL_ADDR   = 16'hFF50;
  localparam logic [15:0] SVM_LEVEL_ADDR  = 16'hFF51;
  localparam logic [7:0]  SVM_CTRL_RST    = 8'h00;
  localparam logic [7:0]  SVM_LEVEL_RST   = 8'h00;
  localparam int          SVM_EN_BIT      = 7;
  localparam int          SVM_MODE_BIT    = 1;
  localparam int          SVM_FLAG_BIT    = 0;
  localparam int          SVM_CODE_W      = 4;
  localparam logic [3:0]  SVM_CODE_MAX    = 4'h9;
  localparam int          SVM_CAUSE_BIT   = 0;
  localparam real         SVM_SETTLE_MS   = 0.2;
  localparam real         SVM_CLK_MHZ     = 125.0;
  localparam int          SVM_SETTLE_CYC  = int'(SVM_SETTLE_MS * 1000.0 * SVM_CLK_MHZ);

  typedef struct packed {
    logic        enable;
    logic        reset_mode;
  } svm_ctrl_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } svm_bus_t;
endpackage

// ---- verif/svm_ctrl_checker.sv ----
/* port assertions for the supply monitor control block.
 assumes one clk_sys domain and a bind onto svm_ctrl. */
`timescale 1ns/1ns
module svm_ctrl_checker
  import svm_pkg::*;
#(parameter int SETTLE_CYC = 20) (
  // clock and resets
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       rst_by_monitor,
  // register port and comparator
  input wire svm_bus_t   bus,
  input wire logic       cmp_low_raw,
  // outputs
  input wire logic [3:0] threshold_code,
  input wire logic       comparator_on,
  input wire logic       low_supply_irq,
  input wire logic       low_supply_reset_req,
  input wire logic       low_supply_irq_mask,
  input wire logic       low_supply_reset_cause
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire wc = bus.wr && bus.addr == SVM_CTRL_ADDR;
  // reset checks must run while rst is high, so they turn the default off
  a_mask_reset: assert property (disable iff (1'b0) rst |=> low_supply_irq_mask)
    else $error("mask not set by reset");
  a_cause_capture: assert property (disable iff (1'b0)
    rst |=> low_supply_reset_cause == $past(rst_by_monitor)) else $error("cause wrong");
  a_regs_clear: assert property (disable iff (1'b0) rst && !rst_by_monitor
    |=> !comparator_on && threshold_code == 4'h0) else $error("regs not cleared");
  a_regs_kept: assert property (disable iff (1'b0) rst && rst_by_monitor
    |=> $stable(threshold_code) && $stable(comparator_on)) else $error("regs lost");
  a_enable_write: assert property (wc |-> ##2 comparator_on == $past(bus.wdata[7], 2))
    else $error("enable not applied");
  a_irq_lag: assert property (low_supply_irq |-> $past(cmp_low_raw, 3))
    else $error("irq without low supply");
  a_req_lag: assert property (low_supply_reset_req |-> $past(cmp_low_raw, 3))
    else $error("reset without low supply");
  a_one_action: assert property (!(low_supply_irq && low_supply_reset_req))
    else $error("both actions at once");
  a_quiet_off: assert property (!comparator_on [*4] |-> !low_supply_irq
    && !low_supply_reset_req) else $error("action while disabled");
  c_irq: cover property (low_supply_irq);
  c_req: cover property (low_supply_reset_req);
  c_cause: cover property (low_supply_reset_cause);
endmodule // svm_ctrl_checker
bind svm_ctrl svm_ctrl_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clk_sys, .rst,
  .rst_by_monitor, .bus, .cmp_low_raw, .threshold_code, .comparator_on, .low_supply_irq,
  .low_supply_reset_req, .low_supply_irq_mask, .low_supply_reset_cause);

// ---- verif/test_low_voltage_detector_control.sv ----
/* self-checking bench: byte model of both registers against svm_ctrl.
 assumes svm_pkg and the checker are compiled first. */
`timescale 1ns/1ns
module test_low_voltage_detector_control;
  import svm_pkg::*;
  logic       clk_sys, rst, rst_by_monitor, cmp_low_raw, irq, req, mask, cause;
  logic       on, settle;
  logic [3:0] code;
  svm_bus_t   bus;
  logic [7:0] rdata;
  int         err_total, checks, ctrl_m, lvl_m;
  svm_ctrl #(.SETTLE_CYC(20)) dut (.clk_sys, .rst, .rst_by_monitor, .bus, .rdata,
    .cmp_low_raw, .threshold_code(code), .comparator_on(on), .low_supply_irq(irq),
    .low_supply_reset_req(req), .low_supply_irq_mask(mask),
    .low_supply_reset_cause(cause), .settle_done(settle));
  initial begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] exp, got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: want %h got %h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys) bus <= '{1'b1, 1'b0, a, d};
    if (a == SVM_CTRL_ADDR) ctrl_m = d & 8'h82;
    if (a == SVM_LEVEL_ADDR) lvl_m = d;
    @(posedge clk_sys) bus.wr <= 1'b0;
  endtask
  // flag reads the settled comparator only while enabled
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys) bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys) bus.rd <= 1'b0;
    #1 chk(a == SVM_CTRL_ADDR ? 8'(ctrl_m | (cmp_low_raw & ctrl_m[7])) :
      a == SVM_LEVEL_ADDR ? 8'(lvl_m) : 8'h00, rdata);
  endtask
  task automatic do_reset(input logic by_mon);
    @(posedge clk_sys) {rst, rst_by_monitor} <= {1'b1, by_mon};
    repeat (3) @(posedge clk_sys);
    {rst, rst_by_monitor} <= 2'b00;
    if (!by_mon) {ctrl_m, lvl_m} = 0;
    #1 chk({7'h0, by_mon}, {7'h0, cause});
    chk(8'h01, {7'h0, mask});
    // synchroniser restarts after reset, so let the flag settle before reads
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {rst, rst_by_monitor, cmp_low_raw} = 3'b100;
    bus = '0;
    void'($urandom(32'he218));
    do_reset(1'b0);
    rd(SVM_CTRL_ADDR);
    rd(SVM_LEVEL_ADDR);
    wr(SVM_LEVEL_ADDR, 8'($urandom % 10));
    wr(SVM_CTRL_ADDR, 8'h83);
    rd(SVM_CTRL_ADDR);
    rd(SVM_LEVEL_ADDR);
    $display("test setup done");
    @(posedge clk_sys) cmp_low_raw <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 chk(8'h01, {7'h0, req});
    rd(SVM_CTRL_ADDR);
    wr(SVM_CTRL_ADDR, 8'h80);
    repeat (4) @(posedge clk_sys);
    #1 chk(8'h02, {6'h0, irq, req});
    $display("test actions done");
    do_reset(1'b1);
    rd(SVM_CTRL_ADDR);
    rd(SVM_LEVEL_ADDR);
    rd(16'hFF52);
    chk({4'h1, lvl_m[3:0]}, {3'h0, on, code});
    repeat (24) @(posedge clk_sys);
    #1 chk(8'h01, {7'h0, settle});
    do_reset(1'b0);
    chk(8'h00, {3'h0, on, code});
    rd(SVM_CTRL_ADDR);
    $display("test resets done");
    summarize;
  end
  // whole run needs well under 1000 cycles
  initial begin
    #100000;
    err_total++;
    summarize;
  end
endmodule // test_low_voltage_detector_control
